// [core/wetting_cfg_pkg.sv]
package wetting_cfg_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int NUM_INPUTS = 24;
  localparam int NUM_PAIRS = 4;
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_SIZE = 6;
  localparam logic [ADDR_W-1:0] PAIR_CUR_ADDR = 6'h1e;
  localparam logic [ADDR_W-1:0] PULSE_CFG_ADDR = 6'h1f;
  localparam logic [ADDR_W-1:0] PULSE_EN_ADDR = 6'h20;
  localparam logic [DATA_W-1:0] REG_RESET = 24'h000000;
  // ************************************************************
  // field layout
  // ************************************************************
  localparam int PAIR_FIELD_W = 3;
  localparam int PAIR_FIELDS_W = PAIR_FIELD_W * NUM_PAIRS;
  localparam int DUR_LSB = 4;
  localparam int DUR_W = 3;
  localparam int GRP_LSB = 0;
  localparam int PULSE_CFG_W = DUR_LSB + DUR_W;
  // ************************************************************
  // current codes and values in mA
  // ************************************************************
  localparam logic [2:0] WC_CODE_OFF = 3'h0;
  localparam logic [2:0] WC_CODE_1MA = 3'h1;
  localparam logic [2:0] WC_CODE_2MA = 3'h2;
  localparam logic [2:0] WC_CODE_5MA = 3'h3;
  localparam logic [2:0] WC_CODE_10MA = 3'h4;
  localparam logic [3:0] MA_0 = 4'h0;
  localparam logic [3:0] MA_1 = 4'h1;
  localparam logic [3:0] MA_2 = 4'h2;
  localparam logic [3:0] MA_5 = 4'h5;
  localparam logic [3:0] MA_10 = 4'ha;
  localparam logic [3:0] MA_15 = 4'hf;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PULSE_UNIT_US = 64;
  localparam int PULSE_UNIT_CYC = (PULSE_UNIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int TIMER_W = 17;
  typedef logic [3:0] ma_t;
  typedef struct packed {
    logic [DUR_W-1:0] duration_sel;
    logic [NUM_GROUPS-1:0] grp_cur;
  } pulse_cfg_s;
endpackage : wetting_cfg_pkg

// [core/wetting_cfg_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - pair current code: 0 off, 1/2/3/4 give 1/2/5/10 mA, 5-7 give 15 mA.
// - pair fields: 18/19 bits 11-9, 16/17 8-6, 14/15 5-3, 12/13 2-0; RW, reset zero.
// - duration field bits 6-4 selects 64 us times (code plus one).
// - group current bit clear gives 10 mA pulse, set gives 15 mA.
// - group bits 0..3 cover inputs 0-5, 6-11, 12-17, 18-23.
// - per-input enable bit n activates pulse current on input n.
// - pulse config at 0x1f, enables at 0x20, both reset to zero.
// - pulse config bits 23-7 read zero, writes ignored.
// - pair current register at 0x1e, resets to zero.
module wetting_cfg_regs #(
  parameter int P_PULSE_UNIT_CYC = wetting_cfg_pkg::PULSE_UNIT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [wetting_cfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [wetting_cfg_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wc_activate,
  input wire logic i_pulse_activate,
  output logic [wetting_cfg_pkg::DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  output wetting_cfg_pkg::ma_t o_pair_ma [wetting_cfg_pkg::NUM_PAIRS],
  output logic o_pulse_active,
  output logic [wetting_cfg_pkg::NUM_INPUTS-1:0] o_pulse_on,
  output wetting_cfg_pkg::ma_t o_pulse_ma [wetting_cfg_pkg::NUM_INPUTS]
);
  import wetting_cfg_pkg::*;

  function automatic ma_t wc_decode(input logic [2:0] code);
    case (code)
      WC_CODE_OFF: wc_decode = MA_0;
      WC_CODE_1MA: wc_decode = MA_1;
      WC_CODE_2MA: wc_decode = MA_2;
      WC_CODE_5MA: wc_decode = MA_5;
      WC_CODE_10MA: wc_decode = MA_10;
      default: wc_decode = MA_15;
    endcase
  endfunction : wc_decode

  function automatic logic [TIMER_W-1:0] pulse_len(input logic [DUR_W-1:0] sel);
    pulse_len = TIMER_W'((int'(sel) + 1) * P_PULSE_UNIT_CYC - 1);
  endfunction : pulse_len

  // ************************************************************
  // register file
  // ************************************************************
  logic [PAIR_FIELDS_W-1:0] pair_cur_q;
  pulse_cfg_s pulse_cfg_q;
  logic [NUM_INPUTS-1:0] pulse_en_q;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pair_cur_q <= PAIR_FIELDS_W'(REG_RESET);
    end else if (i_wr_en && i_addr == PAIR_CUR_ADDR) begin
      pair_cur_q <= i_wr_data[PAIR_FIELDS_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_cfg_q <= PULSE_CFG_W'(REG_RESET);
    end else if (i_wr_en && i_addr == PULSE_CFG_ADDR) begin
      pulse_cfg_q <= i_wr_data[PULSE_CFG_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_en_q <= NUM_INPUTS'(REG_RESET);
    end else if (i_wr_en && i_addr == PULSE_EN_ADDR) begin
      pulse_en_q <= i_wr_data[NUM_INPUTS-1:0];
    end
  end

  // unmapped reads return zero rather than stale data
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= REG_RESET;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        case (i_addr)
          PAIR_CUR_ADDR: o_rd_data <= DATA_W'(pair_cur_q);
          PULSE_CFG_ADDR: o_rd_data <= DATA_W'(pulse_cfg_q);
          PULSE_EN_ADDR: o_rd_data <= pulse_en_q;
          default: o_rd_data <= REG_RESET;
        endcase
      end
    end
  end

  // ************************************************************
  // applied settings
  // ************************************************************
  // settings are sampled at activation so a write mid-pulse cannot glitch the sources
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        o_pair_ma[p] <= MA_0;
      end
    end else if (i_wc_activate) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        o_pair_ma[p] <= wc_decode(pair_cur_q[p*PAIR_FIELD_W +: PAIR_FIELD_W]);
      end
    end
  end

  logic [TIMER_W-1:0] timer_q;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_q <= '0;
      o_pulse_active <= 1'b0;
    end else if (i_pulse_activate && !o_pulse_active) begin
      timer_q <= pulse_len(pulse_cfg_q.duration_sel);
      o_pulse_active <= 1'b1;
    end else if (o_pulse_active) begin
      timer_q <= timer_q - TIMER_W'(1);
      o_pulse_active <= (timer_q != '0);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int n = 0; n < NUM_INPUTS; n++) begin
        o_pulse_ma[n] <= MA_0;
      end
    end else if (i_pulse_activate && !o_pulse_active) begin
      for (int n = 0; n < NUM_INPUTS; n++) begin
        o_pulse_ma[n] <= pulse_cfg_q.grp_cur[n / GROUP_SIZE] ? MA_15 : MA_10;
      end
    end
  end

  // enables captured at start, so a host write mid-pulse leaves the running pulse alone
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pulse_on <= '0;
    end else if (i_pulse_activate && !o_pulse_active) begin
      o_pulse_on <= pulse_en_q;
    end else if (o_pulse_active && timer_q == '0) begin
      o_pulse_on <= '0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  pulse_rsvd_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_rd_en && i_addr == PULSE_CFG_ADDR) |=> o_rd_data[DATA_W-1:PULSE_CFG_W] == '0)
    else $error("reserved pulse config bits read nonzero");

  pair_readback_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_wr_en && i_addr == PAIR_CUR_ADDR) ##1 (i_rd_en && i_addr == PAIR_CUR_ADDR && !i_wr_en)
    |=> o_rd_data[PAIR_FIELDS_W-1:0] == $past(i_wr_data[PAIR_FIELDS_W-1:0], 2))
    else $error("pair current readback mismatch");

  enable_readback_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_wr_en && i_addr == PULSE_EN_ADDR) ##1 (i_rd_en && i_addr == PULSE_EN_ADDR && !i_wr_en)
    |=> o_rd_data == $past(i_wr_data, 2))
    else $error("pulse enable readback mismatch");

  pair_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_wc_activate && pair_cur_q[PAIR_FIELDS_W-1 -: PAIR_FIELD_W] >= 3'h5) |=> o_pair_ma[3] == MA_15)
    else $error("codes 5 to 7 must give 15 mA");

  pair_low_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_wc_activate && pair_cur_q[2:0] == WC_CODE_5MA) |=> o_pair_ma[0] == MA_5)
    else $error("code 3 must give 5 mA");

  pulse_shortest_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_pulse_activate && !o_pulse_active && pulse_cfg_q.duration_sel == '0)
    |=> timer_q == TIMER_W'(P_PULSE_UNIT_CYC - 1) && o_pulse_active)
    else $error("code 0 pulse length wrong");

  pulse_end_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (o_pulse_active && timer_q == '0) |=> !o_pulse_active && o_pulse_on == '0)
    else $error("pulse did not end on time");

  group_current_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_pulse_activate && !o_pulse_active)
    |=> o_pulse_ma[17] == ($past(pulse_cfg_q.grp_cur[2]) ? MA_15 : MA_10)
        && o_pulse_ma[18] == ($past(pulse_cfg_q.grp_cur[3]) ? MA_15 : MA_10))
    else $error("group current mapped to wrong inputs");

  pulse_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_pulse_activate && !o_pulse_active) |=> o_pulse_on == $past(pulse_en_q))
    else $error("pulse enables not applied");

  rd_valid_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_rd_en |=> o_rd_valid)
    else $error("read data not flagged valid");

  pair_upper_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_rd_en && i_addr == PAIR_CUR_ADDR) |=> o_rd_data[DATA_W-1:PAIR_FIELDS_W] == '0)
    else $error("unused pair register bits read nonzero");

  unmapped_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_rd_en && i_addr != PAIR_CUR_ADDR && i_addr != PULSE_CFG_ADDR && i_addr != PULSE_EN_ADDR)
    |=> o_rd_data == '0)
    else $error("unmapped read returned data");

  pair_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !i_wc_activate |=> o_pair_ma[0] == $past(o_pair_ma[0]) && o_pair_ma[3] == $past(o_pair_ma[3]))
    else $error("pair current changed without activation");

  pulse_no_restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (o_pulse_active && i_pulse_activate && timer_q != '0)
    |=> o_pulse_active && timer_q == $past(timer_q) - TIMER_W'(1))
    else $error("pulse restarted while active");

  pulse_idle_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !o_pulse_active |-> o_pulse_on == '0)
    else $error("pulse current on while idle");

  group_edges_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_pulse_activate && !o_pulse_active)
    |=> o_pulse_ma[5] == ($past(pulse_cfg_q.grp_cur[0]) ? MA_15 : MA_10)
        && o_pulse_ma[6] == ($past(pulse_cfg_q.grp_cur[1]) ? MA_15 : MA_10)
        && o_pulse_ma[12] == ($past(pulse_cfg_q.grp_cur[2]) ? MA_15 : MA_10))
    else $error("group boundary current wrong");
endmodule : wetting_cfg_regs

// [test/wetting_host_model.sv]
`timescale 1ns/1ps
module wetting_host_model (
  input wire logic i_sys_clk,
  input wire logic [wetting_cfg_pkg::DATA_W-1:0] i_rd_data,
  input wire logic i_rd_valid,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [wetting_cfg_pkg::ADDR_W-1:0] o_addr,
  output logic [wetting_cfg_pkg::DATA_W-1:0] o_wr_data
);
  import wetting_cfg_pkg::*;
  // ************************************************************
  // decoded register frames, driven on the falling edge
  // ************************************************************
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 6'h00;
    o_wr_data = 24'h000000;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge i_sys_clk);
    o_addr = a;
    o_wr_data = d;
    o_wr_en = 1'b1;
    @(negedge i_sys_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
    @(negedge i_sys_clk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_sys_clk);
    d = i_rd_data;
    v = i_rd_valid;
    o_rd_en = 1'b0;
    o_addr = ~a;
  endtask : rd
  // write, then read the same offset on the very next cycle
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] d,
    output logic v);
    @(negedge i_sys_clk);
    o_addr = a;
    o_wr_data = wd;
    o_wr_en = 1'b1;
    @(negedge i_sys_clk);
    o_wr_en = 1'b0;
    o_rd_en = 1'b1;
    @(negedge i_sys_clk);
    d = i_rd_data;
    v = i_rd_valid;
    o_rd_en = 1'b0;
    o_addr = ~a;
    o_wr_data = ~wd;
  endtask : wr_rd
endmodule : wetting_host_model

// [test/wetting_current_pulse_config_tb_top.sv]
`timescale 1ns/1ps
module wetting_current_pulse_config_tb_top;
  import wetting_cfg_pkg::*;
  localparam int UNIT = 4;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic wr_en, rd_en, rvalid, v, pactive;
  logic wc_act = 1'b0;
  logic pulse_act = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, got;
  logic [NUM_INPUTS-1:0] pon;
  ma_t pair_ma [NUM_PAIRS];
  ma_t pulse_ma [NUM_INPUTS];
  int bad_count = 0;
  int checks_done = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  wetting_cfg_regs #(.P_PULSE_UNIT_CYC(UNIT)) dut_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wdata), .i_wc_activate(wc_act),
    .i_pulse_activate(pulse_act), .o_rd_data(rdata), .o_rd_valid(rvalid), .o_pair_ma(pair_ma),
    .o_pulse_active(pactive), .o_pulse_on(pon), .o_pulse_ma(pulse_ma));
  wetting_host_model host_u (.i_sys_clk(i_sys_clk), .i_rd_data(rdata), .i_rd_valid(rvalid),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdata));
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host_u.rd(a, got, v);
    chk("read valid", v, 1'b1);
    chk(what, got, exp);
  endtask : rd_chk
  function automatic ma_t wc_ma(input logic [2:0] c);
    case (c)
      3'h0: return MA_0;
      3'h1: return MA_1;
      3'h2: return MA_2;
      3'h3: return MA_5;
      3'h4: return MA_10;
      default: return MA_15;
    endcase
  endfunction : wc_ma
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [2:0] c;
    logic [3:0] g;
    int n;
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_nrst = 1'b1;
    rd_chk("pair reset", PAIR_CUR_ADDR, REG_RESET);
    rd_chk("cfg reset", PULSE_CFG_ADDR, REG_RESET);
    rd_chk("enable reset", PULSE_EN_ADDR, REG_RESET);
    host_u.wr(PAIR_CUR_ADDR, 24'hffffff);
    rd_chk("pair mask", PAIR_CUR_ADDR, 24'h000fff);
    host_u.wr(PULSE_CFG_ADDR, 24'hffffff);
    rd_chk("cfg mask", PULSE_CFG_ADDR, 24'h00007f);
    host_u.wr(PULSE_EN_ADDR, 24'ha5c3e1);
    rd_chk("enable readback", PULSE_EN_ADDR, 24'ha5c3e1);
    host_u.wr_rd(PULSE_EN_ADDR, 24'h5a3c1e, got, v);
    chk("enable back to back", got, 24'h5a3c1e);
    chk("read valid", v, 1'b1);
    host_u.wr(6'h21, 24'hffffff);
    rd_chk("unmapped", 6'h21, 24'h000000);
    $display("register test done");
    for (int k = 0; k < 8; k++) begin
      host_u.wr(PAIR_CUR_ADDR, {12'h000, 3'(k + 3), 3'(k + 2), 3'(k + 1), 3'(k)});
      @(negedge i_sys_clk) wc_act = 1'b1;
      @(negedge i_sys_clk) wc_act = 1'b0;
      @(negedge i_sys_clk);
      for (int j = 0; j < NUM_PAIRS; j++) chk("pair current", pair_ma[j], wc_ma(3'(k + j)));
    end
    // a write alone must not move the applied current
    host_u.wr(PAIR_CUR_ADDR, 24'h000000);
    @(negedge i_sys_clk);
    chk("pair held", pair_ma[0], MA_15);
    host_u.wr_rd(PAIR_CUR_ADDR, 24'h000abc, got, v);
    chk("pair back to back", got, 24'h000abc);
    chk("read valid", v, 1'b1);
    chk("pair still held", pair_ma[0], MA_15);
    @(negedge i_sys_clk) wc_act = 1'b1;
    @(negedge i_sys_clk) wc_act = 1'b0;
    @(negedge i_sys_clk);
    chk("pair new low", pair_ma[0], MA_10);
    chk("pair new high", pair_ma[3], MA_15);
    $display("pair current test done");
    for (int t = 0; t < 3; t++) begin
      c = (t == 2) ? 3'h0 : (t == 1) ? 3'h7 : 3'h1;
      g = (t == 2) ? 4'h3 : (t == 1) ? 4'ha : 4'h5;
      host_u.wr(PULSE_CFG_ADDR, {17'h00000, c, g});
      host_u.wr(PULSE_EN_ADDR, 24'h841041);
      @(negedge i_sys_clk) pulse_act = 1'b1;
      @(negedge i_sys_clk) pulse_act = 1'b0;
      n = 0;
      // a second start mid-pulse must not stretch it
      for (int i = 0; i < 300; i++) begin
        if (pactive === 1'b1) begin
          if (n == 1) begin
            chk("pulse on", pon, 24'h841041);
            for (int p = 0; p < NUM_INPUTS; p++) chk("pulse ma", pulse_ma[p], g[p / GROUP_SIZE] ? MA_15 : MA_10);
          end
          n++;
        end
        @(negedge i_sys_clk) pulse_act = (n == 2);
      end
      chk("pulse length", n, UNIT * (c + 1));
      chk("pulse off", pon, 24'h000000);
    end
    $display("pulse test done");
    // reset in mid-pulse must clear the outputs and the written registers
    host_u.wr(PULSE_EN_ADDR, 24'hffffff);
    @(negedge i_sys_clk) pulse_act = 1'b1;
    @(negedge i_sys_clk) pulse_act = 1'b0;
    chk("pulse started", pactive, 1'b1);
    i_nrst = 1'b0;
    @(negedge i_sys_clk);
    chk("reset pulse", pactive, 1'b0);
    chk("reset pulse on", pon, 24'h000000);
    chk("reset pair ma", pair_ma[3], MA_0);
    @(negedge i_sys_clk) i_nrst = 1'b1;
    rd_chk("pair after reset", PAIR_CUR_ADDR, REG_RESET);
    rd_chk("cfg after reset", PULSE_CFG_ADDR, REG_RESET);
    rd_chk("enable after reset", PULSE_EN_ADDR, REG_RESET);
    $display("reset test done");
    close_out();
  end
endmodule : wetting_current_pulse_config_tb_top
